// *** core/mspg_pkg.sv ***
// speed-profile generator: shared constants, command codes, register map, types
// assumes a 25 MHz core clock and a 40 MHz reference figure for ramp timing
package mspg_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam longint REF_CLK_HZ = 40_000_000;
  localparam longint CORE_CLK_HZ = 25_000_000;
  localparam longint RAMP_UNIT_REF = 8;
  localparam int RAMP_UNIT_CYC = int'(RAMP_UNIT_REF * CORE_CLK_HZ / REF_CLK_HZ);
  localparam longint MULT_DEN = 200_000;
  localparam logic [16:0] ACC_UNIT = 17'(MULT_DEN * CORE_CLK_HZ / REF_CLK_HZ);
  // ************************************************************
  // commands and limits
  // ************************************************************
  localparam logic [15:0] CMD_STOP = 16'h0049;
  localparam logic [15:0] CMD_SLOWDOWN = 16'h004A;
  localparam logic [15:0] CMD_START_FL = 16'h0050;
  localparam logic [15:0] CMD_START_FH = 16'h0051;
  localparam logic [15:0] CMD_START_EXT = 16'h0052;
  localparam logic [15:0] CMD_START_AUTO = 16'h0053;
  localparam logic [16:0] SPEED_MAX = 17'h186A0;
  localparam logic [15:0] SRANGE_MAX = 16'hC350;
  localparam logic [10:0] MULT_MIN = 11'h002;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_POS = 8'h04;
  localparam logic [7:0] ADDR_FL = 8'h08;
  localparam logic [7:0] ADDR_FH = 8'h0C;
  localparam logic [7:0] ADDR_UR = 8'h10;
  localparam logic [7:0] ADDR_DR = 8'h14;
  localparam logic [7:0] ADDR_MG = 8'h18;
  localparam logic [7:0] ADDR_DP = 8'h1C;
  localparam logic [7:0] ADDR_US = 8'h20;
  localparam logic [7:0] ADDR_DS = 8'h24;
  localparam logic [7:0] ADDR_FA = 8'h28;
  localparam logic [7:0] ADDR_MODE = 8'h2C;
  localparam logic [7:0] ADDR_STAT = 8'h30;
  localparam logic [7:0] ADDR_REM = 8'h34;
  localparam int MODE_POS_BIT = 0;
  localparam int MODE_MSDP_BIT = 1;
  localparam int MODE_SCURVE_BIT = 2;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [16:0] RST_SPEED = 17'h00001;
  localparam logic [15:0] RST_RATE = 16'h0001;
  localparam logic [10:0] RST_MG = 11'h0C7;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONST_FL = 3'b001,
    ST_CONST_FH = 3'b010,
    ST_ACCEL = 3'b011,
    ST_CRUISE = 3'b100,
    ST_DECEL = 3'b101
  } mspg_state_e;
  typedef struct packed {
    logic [27:0] positioning_amount;
    logic [16:0] initial_speed;
    logic [16:0] top_speed;
    logic [15:0] accel_rate;
    logic [15:0] decel_rate;
    logic [10:0] speed_multiplier;
    logic [23:0] slowdown_point;
    logic [15:0] scurve_accel_range;
    logic [15:0] scurve_decel_range;
    logic [16:0] correction_speed;
    logic pos_mode;
    logic slowdown_point_manual_sel;
    logic scurve_select;
  } mspg_cfg_s;
endpackage

// *** core/mspg_pulse_gen.sv ***
// speed-profile generator: phase-accumulating pulse source
// assumes level below the accumulator unit so at most one pulse per cycle
`timescale 1ns/1ps
`default_nettype none
module mspg_pulse_gen #(
  parameter int LVL_W = 17
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [LVL_W-1:0] level,
  input wire logic [10:0] mult,
  output logic pulse_r
);
  logic [29:0] acc_r;
  logic [29:0] limit;
  logic [29:0] sum;

  initial begin
    if (LVL_W < 1 || LVL_W > 17) begin
      $error("mspg_pulse_gen: LVL_W out of range");
    end
  end

  // threshold = (multiplier + 1) * unit, in core cycles per pulse times level
  assign limit = 30'((30'(mult) + 30'h1) * 30'(mspg_pkg::ACC_UNIT));
  assign sum = acc_r + 30'(level);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      acc_r <= 30'h0;
      pulse_r <= 1'b0;
    end else if (sum >= limit) begin
      acc_r <= sum - limit;
      pulse_r <= 1'b1;
    end else begin
      acc_r <= sum;
      pulse_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** core/mspg_core.sv ***
// speed-profile generator: register file, command decode, profile state machine
// assumes a one-cycle strobe register port on core_clk; pulses go to a motor driver
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - start 0050h: constant initial speed, stops
// - start 0051h: constant top speed
// - start 0052h: ramp up, external slowdown stop
// - start 0053h: ramp with automatic slowdown point
// - 28-bit signed target, live override
// - clamp speeds above 186A0h
// - clamp S-curve ranges above 0C350h
// - initial speed scaled, live override
// - top speed scaled, live override
// - linear ramp step is (rate+1) units of 8 ref clocks
// - S-curve without range doubles step time
// - S-curve range adds twice range steps
// - zero decel rate uses accel rate
// - deceleration mirrors acceleration timing
// - multiplier is 40 MHz over (set+1)*200000
// - settings retained between motions
// - manual point: decelerate when remaining <= point
// - auto point: signed 24-bit offset
module mspg_core (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic pulse_out,
  output logic dir_out,
  output logic busy_out
);
  // ************************************************************
  // declarations
  // ************************************************************
  mspg_pkg::mspg_cfg_s cfg_r;
  mspg_pkg::mspg_state_e state_r;
  mspg_pkg::mspg_state_e state_nxt;
  logic [16:0] lvl_r;
  logic [16:0] lvl_nxt;
  logic [27:0] done_r;
  logic [27:0] accel_pls_r;
  logic slow_req_r;
  logic [2:0] unit_cnt_r;
  logic [17:0] step_cnt_r;
  logic gen_pulse;
  logic [16:0] fl;
  logic [16:0] fh;
  logic [16:0] span;
  logic [15:0] rate;
  logic [15:0] srange;
  logic [16:0] s_width;
  logic in_s;
  logic [17:0] step_len;
  logic unit_tick;
  logic step_tick;
  logic ramping;
  logic [27:0] abs_target;
  logic [27:0] remaining;
  logic [27:0] point;
  logic [28:0] auto_point;
  logic pos_decel;
  logic cmd_wr;
  logic cmd_stop;
  logic cmd_slow;
  logic cmd_fl;
  logic cmd_fh;
  logic cmd_ext;
  logic cmd_auto;
  logic run;

  function automatic logic [16:0] clamp_speed(input logic [16:0] v);
    clamp_speed = (v > mspg_pkg::SPEED_MAX) ? mspg_pkg::SPEED_MAX : v;
  endfunction

  function automatic logic [15:0] clamp_range(input logic [15:0] v);
    clamp_range = (v > mspg_pkg::SRANGE_MAX) ? mspg_pkg::SRANGE_MAX : v;
  endfunction

  // ************************************************************
  // command decode
  // ************************************************************
  assign cmd_wr = bus_wr && (bus_addr == mspg_pkg::ADDR_CMD);
  assign cmd_stop = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_STOP);
  assign cmd_slow = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_SLOWDOWN);
  assign cmd_fl = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_START_FL);
  assign cmd_fh = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_START_FH);
  assign cmd_ext = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_START_EXT);
  assign cmd_auto = cmd_wr && (bus_wdata[15:0] == mspg_pkg::CMD_START_AUTO);

  // ************************************************************
  // register file
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_r <= '0;
      cfg_r.initial_speed <= mspg_pkg::RST_SPEED;
      cfg_r.top_speed <= mspg_pkg::RST_SPEED;
      cfg_r.accel_rate <= mspg_pkg::RST_RATE;
      cfg_r.speed_multiplier <= mspg_pkg::RST_MG;
    end else if (bus_wr) begin
      // values persist until rewritten
      case (bus_addr)
        mspg_pkg::ADDR_POS: cfg_r.positioning_amount <= bus_wdata[27:0];
        mspg_pkg::ADDR_FL: cfg_r.initial_speed <= bus_wdata[16:0];
        mspg_pkg::ADDR_FH: cfg_r.top_speed <= bus_wdata[16:0];
        mspg_pkg::ADDR_UR: cfg_r.accel_rate <= bus_wdata[15:0];
        mspg_pkg::ADDR_DR: cfg_r.decel_rate <= bus_wdata[15:0];
        mspg_pkg::ADDR_MG: begin
          // below the minimum the multiplier would exceed the speed range
          if (bus_wdata[10:0] >= mspg_pkg::MULT_MIN) begin
            cfg_r.speed_multiplier <= bus_wdata[10:0];
          end
        end
        mspg_pkg::ADDR_DP: cfg_r.slowdown_point <= bus_wdata[23:0];
        mspg_pkg::ADDR_US: cfg_r.scurve_accel_range <= bus_wdata[15:0];
        mspg_pkg::ADDR_DS: cfg_r.scurve_decel_range <= bus_wdata[15:0];
        mspg_pkg::ADDR_FA: cfg_r.correction_speed <= bus_wdata[16:0];
        mspg_pkg::ADDR_MODE: begin
          cfg_r.pos_mode <= bus_wdata[mspg_pkg::MODE_POS_BIT];
          cfg_r.slowdown_point_manual_sel <= bus_wdata[mspg_pkg::MODE_MSDP_BIT];
          cfg_r.scurve_select <= bus_wdata[mspg_pkg::MODE_SCURVE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0;
    end else if (bus_rd) begin
      case (bus_addr)
        mspg_pkg::ADDR_POS: bus_rdata <= {4'h0, cfg_r.positioning_amount};
        mspg_pkg::ADDR_FL: bus_rdata <= {15'h0, cfg_r.initial_speed};
        mspg_pkg::ADDR_FH: bus_rdata <= {15'h0, cfg_r.top_speed};
        mspg_pkg::ADDR_UR: bus_rdata <= {16'h0, cfg_r.accel_rate};
        mspg_pkg::ADDR_DR: bus_rdata <= {16'h0, cfg_r.decel_rate};
        mspg_pkg::ADDR_MG: bus_rdata <= {21'h0, cfg_r.speed_multiplier};
        mspg_pkg::ADDR_DP: bus_rdata <= {8'h0, cfg_r.slowdown_point};
        mspg_pkg::ADDR_US: bus_rdata <= {16'h0, cfg_r.scurve_accel_range};
        mspg_pkg::ADDR_DS: bus_rdata <= {16'h0, cfg_r.scurve_decel_range};
        mspg_pkg::ADDR_FA: bus_rdata <= {15'h0, cfg_r.correction_speed};
        mspg_pkg::ADDR_MODE: bus_rdata <= {29'h0, cfg_r.scurve_select,
                                           cfg_r.slowdown_point_manual_sel, cfg_r.pos_mode};
        mspg_pkg::ADDR_STAT: bus_rdata <= {11'h0, run, state_r, lvl_r};
        mspg_pkg::ADDR_REM: bus_rdata <= {4'h0, remaining};
        default: bus_rdata <= 32'h0;
      endcase
    end else begin
      bus_rdata <= 32'h0;
    end
  end

  // ************************************************************
  // effective settings
  // ************************************************************
  assign fl = clamp_speed(cfg_r.initial_speed);
  assign fh = clamp_speed(cfg_r.top_speed);
  assign span = (fh > fl) ? (fh - fl) : 17'h0;
  // a zero decel rate falls back to the accel rate
  assign rate = (state_r == mspg_pkg::ST_DECEL && cfg_r.decel_rate != 16'h0) ?
                cfg_r.decel_rate : cfg_r.accel_rate;
  assign srange = clamp_range((state_r == mspg_pkg::ST_DECEL) ?
                  cfg_r.scurve_decel_range : cfg_r.scurve_accel_range);
  // zero range: whole span is curved, giving twice the linear time
  assign s_width = (srange == 16'h0) ? {1'b0, span[16:1]} : {1'b0, srange};
  // levels within the curved bands take twice the units per step
  assign in_s = cfg_r.scurve_select && ((srange == 16'h0) ||
                (lvl_r < 17'(fl + s_width)) || (18'(lvl_r) + 18'(s_width) >= 18'(fh)));
  // base step is rate+1 units; step_tick doubles it inside the curved bands
  assign step_len = {2'h0, rate} + 18'h1;
  assign ramping = (state_r == mspg_pkg::ST_ACCEL) || (state_r == mspg_pkg::ST_DECEL);
  assign run = (state_r != mspg_pkg::ST_IDLE);

  // ************************************************************
  // ramp step timing
  // ************************************************************
  // one unit is 8 reference clocks, carried as core-clock cycles
  assign unit_tick = ramping && (unit_cnt_r == 3'(mspg_pkg::RAMP_UNIT_CYC - 1));
  assign step_tick = unit_tick &&
                     (step_cnt_r + 18'h1 >= (in_s ? 18'(step_len << 1) : step_len));

  always_ff @(posedge core_clk) begin
    if (sys_rst || !ramping || state_nxt != state_r) begin
      unit_cnt_r <= 3'h0;
    end else if (unit_tick) begin
      unit_cnt_r <= 3'h0;
    end else begin
      unit_cnt_r <= unit_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !ramping || state_nxt != state_r) begin
      step_cnt_r <= 18'h0;
    end else if (step_tick) begin
      step_cnt_r <= 18'h0;
    end else if (unit_tick) begin
      step_cnt_r <= step_cnt_r + 18'h1;
    end
  end

  // ************************************************************
  // positioning count and slowdown point
  // ************************************************************
  assign abs_target = cfg_r.positioning_amount[27] ?
                      28'(-cfg_r.positioning_amount) : cfg_r.positioning_amount;
  assign remaining = (done_r >= abs_target) ? 28'h0 : (abs_target - done_r);
  // auto point: pulses spent accelerating plus a signed offset
  assign auto_point = 29'(accel_pls_r) +
                      29'({{5{cfg_r.slowdown_point[23]}}, cfg_r.slowdown_point});
  assign point = cfg_r.slowdown_point_manual_sel ? {4'h0, cfg_r.slowdown_point} :
                 (auto_point[28] ? 28'h0 : auto_point[27:0]);
  assign pos_decel = cfg_r.pos_mode && (remaining <= point) && !slow_req_r;

  always_ff @(posedge core_clk) begin
    // cleared on start so the count left after a motion stays readable
    if (sys_rst || (state_r == mspg_pkg::ST_IDLE && state_nxt != mspg_pkg::ST_IDLE)) begin
      done_r <= 28'h0;
    end else if (gen_pulse && run) begin
      done_r <= done_r + 28'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_r == mspg_pkg::ST_IDLE) begin
      accel_pls_r <= 28'h0;
    end else if (gen_pulse && state_r == mspg_pkg::ST_ACCEL) begin
      accel_pls_r <= accel_pls_r + 28'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_r == mspg_pkg::ST_IDLE) begin
      slow_req_r <= 1'b0;
    end else if (cmd_slow) begin
      slow_req_r <= 1'b1;
    end
  end

  // ************************************************************
  // profile state machine
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      mspg_pkg::ST_IDLE: begin
        if (cmd_fl) begin
          state_nxt = mspg_pkg::ST_CONST_FL;
        end else if (cmd_fh) begin
          state_nxt = mspg_pkg::ST_CONST_FH;
        end else if (cmd_ext || cmd_auto) begin
          state_nxt = mspg_pkg::ST_ACCEL;
        end
      end
      mspg_pkg::ST_CONST_FL: begin
        if (cmd_slow) begin
          state_nxt = mspg_pkg::ST_IDLE;
        end
      end
      mspg_pkg::ST_CONST_FH: begin
        if (cmd_slow) begin
          state_nxt = mspg_pkg::ST_DECEL;
        end
      end
      mspg_pkg::ST_ACCEL: begin
        if (cmd_slow || pos_decel) begin
          state_nxt = mspg_pkg::ST_DECEL;
        end else if (lvl_r >= fh) begin
          state_nxt = mspg_pkg::ST_CRUISE;
        end
      end
      mspg_pkg::ST_CRUISE: begin
        if (cmd_slow || pos_decel) begin
          state_nxt = mspg_pkg::ST_DECEL;
        end else if (lvl_r < fh) begin
          state_nxt = mspg_pkg::ST_ACCEL;
        end
      end
      mspg_pkg::ST_DECEL: begin
        // positioning without a slowdown command keeps feeding at initial speed until the count runs out
        if (lvl_r <= fl && (!cfg_r.pos_mode || slow_req_r || cmd_slow)) begin
          state_nxt = mspg_pkg::ST_IDLE;
        end
      end
      default: state_nxt = mspg_pkg::ST_IDLE;
    endcase
    if (run && cfg_r.pos_mode && remaining == 28'h0) begin
      state_nxt = mspg_pkg::ST_IDLE;
    end
    if (cmd_stop) begin
      state_nxt = mspg_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= mspg_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // instantaneous speed level
  // ************************************************************
  always_comb begin
    lvl_nxt = lvl_r;
    case (state_r)
      mspg_pkg::ST_IDLE: lvl_nxt = cmd_fh ? fh : fl;
      mspg_pkg::ST_CONST_FL: lvl_nxt = fl;
      mspg_pkg::ST_CONST_FH: lvl_nxt = fh;
      mspg_pkg::ST_CRUISE: lvl_nxt = (lvl_r > fh) ? fh : lvl_r;
      mspg_pkg::ST_ACCEL: begin
        if (lvl_r < fl) begin
          lvl_nxt = fl;
        end else if (step_tick && lvl_r < fh) begin
          lvl_nxt = lvl_r + 17'h1;
        end
      end
      mspg_pkg::ST_DECEL: begin
        if (lvl_r < fl) begin
          lvl_nxt = fl;
        end else if (step_tick && lvl_r > fl) begin
          lvl_nxt = lvl_r - 17'h1;
        end
      end
      default: lvl_nxt = fl;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lvl_r <= mspg_pkg::RST_SPEED;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  // ************************************************************
  // pulse output
  // ************************************************************
  mspg_pulse_gen #(
    .LVL_W(17)
  ) u_pulse (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(run),
    .level(lvl_r),
    .mult(cfg_r.speed_multiplier),
    .pulse_r(gen_pulse)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pulse_out <= 1'b0;
      dir_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      pulse_out <= gen_pulse && run;
      dir_out <= cfg_r.positioning_amount[27];
      busy_out <= run;
    end
  end
endmodule
`default_nettype wire

// *** sim/mspg_checker.sv ***
// checker for the speed-profile generator: register port answers and pulse outputs
// assumes it is bound onto mspg_core and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module mspg_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic busy_out
);
  // ************************************************************
  // decoded requests
  // ************************************************************
  logic cmd_wr;
  logic start_wr;
  logic pos_wr;
  assign cmd_wr = bus_wr && bus_addr == mspg_pkg::ADDR_CMD;
  // start codes 0050h..0053h share the upper fourteen bits
  assign start_wr = cmd_wr && bus_wdata[15:2] == 14'h0014;
  assign pos_wr = bus_wr && bus_addr == mspg_pkg::ADDR_POS;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_RD_UNMAPPED: assert property ($past(bus_rd) && $past(bus_addr) > mspg_pkg::ADDR_REM
    |-> bus_rdata == 32'h0) else $error("unmapped read returned data");
  AST_MG_RANGE: assert property ($past(bus_rd) && $past(bus_addr) == mspg_pkg::ADDR_MG
    |-> bus_rdata[31:11] == 21'h0 && bus_rdata[10:0] >= mspg_pkg::MULT_MIN)
    else $error("multiplier outside its range");
  AST_STAT_CLAMP: assert property ($past(bus_rd) && $past(bus_addr) == mspg_pkg::ADDR_STAT
    |-> bus_rdata[16:0] <= mspg_pkg::SPEED_MAX) else $error("level above speed limit");
  AST_PULSE_ONE: assert property (pulse_out |=> !pulse_out)
    else $error("pulse longer than one cycle");
  AST_PULSE_BUSY: assert property (pulse_out |-> busy_out || $past(busy_out)
    || $past(busy_out, 2)) else $error("pulse while idle");
  AST_STOP: assert property (cmd_wr && bus_wdata[15:0] == mspg_pkg::CMD_STOP
    |-> ##2 !busy_out) else $error("immediate stop did not halt");
  AST_START: assert property (start_wr && !busy_out && !$past(bus_wr) |-> ##2 busy_out)
    else $error("start from idle did not run");
  AST_BUSY_CAUSE: assert property ($rose(busy_out) |-> $past(start_wr, 2))
    else $error("motion began without a start");
  AST_DIR: assert property (pos_wr ##1 !pos_wr |-> ##1 dir_out == $past(bus_wdata[27], 2))
    else $error("direction not the target sign");
  COV_START: cover property (start_wr ##2 busy_out);
  COV_REVERSE: cover property (pulse_out && dir_out);
  COV_END: cover property ($fell(busy_out));
endmodule
`default_nettype wire

// *** sim/mspg_drv_model.sv ***
// motor driver model: counts command pulses and tracks the net position
// assumes one-cycle pulses on core_clk and a level direction input
`timescale 1ns/1ps
`default_nettype none
module mspg_drv_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic step_in,
  input wire logic dir_in,
  output logic [31:0] step_cnt,
  output logic [31:0] net_pos
);
  // ************************************************************
  // step counting
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      step_cnt <= 32'h0;
      net_pos <= 32'h0;
    end else if (step_in) begin
      step_cnt <= step_cnt + 32'h1;
      net_pos <= dir_in ? net_pos - 32'h1 : net_pos + 32'h1;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// testbench for the speed-profile generator: register tasks and motion sequences
// assumes mspg_core, its checker bound below and a driver model on the pulse outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic core_clk;
  logic sys_rst;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic pulse_out;
  logic dir_out;
  logic busy_out;
  logic [31:0] step_cnt;
  logic [31:0] net_pos;
  logic [31:0] d;
  logic [31:0] snap;
  logic [31:0] snap_pos;
  int bad_count;
  int samples_checked;
  int n;
  int rs;
  int t;
  mspg_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pulse_out(pulse_out), .dir_out(dir_out), .busy_out(busy_out));
  mspg_drv_model drv (.core_clk(core_clk), .sys_rst(sys_rst), .step_in(pulse_out),
    .dir_in(dir_out), .step_cnt(step_cnt), .net_pos(net_pos));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  // read data is taken in the one cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(posedge core_clk);
    d = bus_rdata;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] ex);
    rd(a);
    `CHK($sformatf("reg_%h", a), ex, d)
  endtask
  // a zero level skips the level compare
  task automatic chk_st(input logic [2:0] st, input logic [16:0] lv);
    rd(mspg_pkg::ADDR_STAT);
    `CHK("state", st, d[19:17])
    if (lv != 17'h0) `CHK("level", lv, d[16:0])
  endtask
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    repeat (4) @(posedge core_clk);
    while (busy_out !== 1'b0 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= lim) begin
      bad_count++;
      $display("CHECK FAILED busy_out timeout");
      complete_run();
    end
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    sys_rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk_reg(mspg_pkg::ADDR_FL, 32'h1);
    chk_reg(mspg_pkg::ADDR_FH, 32'h1);
    chk_reg(mspg_pkg::ADDR_DR, 32'h0);
    chk_reg(mspg_pkg::ADDR_STAT, {15'h0, mspg_pkg::RST_SPEED});
    chk_reg(8'hFC, 32'h0);
    wr(mspg_pkg::ADDR_MG, 32'h1);
    chk_reg(mspg_pkg::ADDR_MG, 32'hC7);
    wr(mspg_pkg::ADDR_MG, 32'h2);
    wr(mspg_pkg::ADDR_FL, 32'h3E8);
    wr(mspg_pkg::ADDR_FH, 32'h1FFFF);
    chk_reg(mspg_pkg::ADDR_FH, 32'h1FFFF);
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_START_FH);
    chk_st(mspg_pkg::ST_CONST_FH, mspg_pkg::SPEED_MAX);
    snap = step_cnt;
    // clamped top speed at multiplier 2 gives 100 pulses in 375 cycles
    repeat (375) @(posedge core_clk);
    d = step_cnt - snap;
    `CHK("rate", 1'b1, d >= 32'h63 && d <= 32'h65)
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_START_FL);
    wr(mspg_pkg::ADDR_FH, 32'h3F8);
    chk_st(mspg_pkg::ST_CONST_FH, 17'h3F8);
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_STOP);
    repeat (3) @(posedge core_clk);
    `CHK("busy_out", 1'b0, busy_out)
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_START_FL);
    chk_st(mspg_pkg::ST_CONST_FL, 17'h3E8);
    wr(mspg_pkg::ADDR_FL, 32'h1FFFF);
    chk_st(mspg_pkg::ST_CONST_FL, mspg_pkg::SPEED_MAX);
    wr(mspg_pkg::ADDR_FL, 32'h3E8);
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_SLOWDOWN);
    wait_idle(8);
    wr(mspg_pkg::ADDR_CMD, 32'h55);
    repeat (4) @(posedge core_clk);
    `CHK("busy_out", 1'b0, busy_out)
    // ramps of 16 levels: linear, S-curve without range, S-curve with range 5
    for (int i = 0; i < 3; i++) begin
      rs = (i == 2) ? 5 : 0;
      t = (16 + 2 * rs) * 2 * mspg_pkg::RAMP_UNIT_CYC * ((i == 1) ? 2 : 1);
      wr(mspg_pkg::ADDR_MODE, (i > 0) ? 32'h4 : 32'h0);
      wr(mspg_pkg::ADDR_US, 32'(rs));
      wr(mspg_pkg::ADDR_DS, 32'(rs));
      wr(mspg_pkg::ADDR_CMD, (i == 2) ? mspg_pkg::CMD_START_AUTO : mspg_pkg::CMD_START_EXT);
      repeat (t * 3 / 4) @(posedge core_clk);
      chk_st(mspg_pkg::ST_ACCEL, 17'h0);
      repeat (t / 4 + 30) @(posedge core_clk);
      chk_st(mspg_pkg::ST_CRUISE, 17'h3F8);
      wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_SLOWDOWN);
      repeat (t * 3 / 4) @(posedge core_clk);
      chk_st(mspg_pkg::ST_DECEL, 17'h0);
      wait_idle(t);
    end
    wr(mspg_pkg::ADDR_DP, 32'h2);
    for (int i = 0; i < 5; i++) begin
      n = (i == 4) ? 3 : 4;
      wr(mspg_pkg::ADDR_MODE, (i == 3) ? 32'h1 : 32'h3);
      wr(mspg_pkg::ADDR_POS, (i == 4) ? 32'h0FFFFFFD : 32'h4);
      snap = step_cnt;
      snap_pos = net_pos;
      wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_START_FL + 16'(i % 4));
      wait_idle(20000);
      `CHK("steps", 32'(n), step_cnt - snap)
      `CHK("net_pos", (i == 4) ? 32'hFFFFFFFD : 32'h4, net_pos - snap_pos)
      `CHK("dir_out", i == 4, dir_out)
      chk_reg(mspg_pkg::ADDR_REM, 32'h0);
    end
    wr(mspg_pkg::ADDR_POS, 32'h64);
    snap = step_cnt;
    wr(mspg_pkg::ADDR_CMD, mspg_pkg::CMD_START_FL);
    wr(mspg_pkg::ADDR_POS, 32'h2);
    wait_idle(20000);
    `CHK("override", 32'h2, step_cnt - snap)
    chk_reg(mspg_pkg::ADDR_FL, 32'h3E8);
    chk_reg(mspg_pkg::ADDR_DP, 32'h2);
    complete_run();
  end
endmodule
bind mspg_core mspg_checker chk (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .pulse_out(pulse_out), .dir_out(dir_out), .busy_out(busy_out));
`default_nettype wire
